/* File: shared/csc_pkg.sv */
// Shared constants, field layouts and carrier types of the charger status/control registers
package csc_pkg;

    // ==========================================================
    // Register offsets and unmapped read value
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] RD_UNMAPPED = 8'hff;

    // ==========================================================
    // Field positions, status register
    localparam int STS_KICK_BIT = 7;
    localparam int STS_BOOST_BIT = 6;
    localparam int STS_SHIP_BIT = 3;
    // Field positions, control register
    localparam int CTRL_RESET_BIT = 7;
    localparam int CTRL_ILIM_HI = 6;
    localparam int CTRL_ILIM_LO = 4;
    localparam int CTRL_FULL_BIT = 3;
    localparam int CTRL_TERM_BIT = 2;
    localparam int CTRL_INHIBIT_BIT = 1;
    localparam int CTRL_QUIET_BIT = 0;

    // ==========================================================
    // Charge state codes
    localparam logic [1:0] ST_READY = 2'h0;
    localparam logic [1:0] ST_CHARGING = 2'h1;
    localparam logic [1:0] ST_DONE = 2'h2;
    localparam logic [1:0] ST_FAULT = 2'h3;

    // Fault codes, lower non-zero code ranks higher
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_LOW_SUPPLY = 3'h2;
    localparam int NUM_FAULTS = 7;
    localparam int FLT_IDX_LOW_SUPPLY = 1;
    localparam int FLT_IDX_TIMER = 4;

    // ==========================================================
    // Reset values
    localparam logic BOOST_RST = 1'b0;
    localparam logic SHIP_RST = 1'b0;
    localparam logic [2:0] ILIM_RST = 3'h0;
    localparam logic FULL_RST = 1'b1;
    localparam logic TERM_RST = 1'b1;
    localparam logic QUIET_RST = 1'b0;
    localparam logic INHIBIT_RST_DEF = 1'b0;

    // Input limit codes picked by the limit select pin in default mode
    localparam logic [2:0] ILIM_PSEL_HIGH = 3'h2;
    localparam logic [2:0] ILIM_PSEL_LOW = 3'h4;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int PULSE_TIME_US = 128;
    localparam int PULSE_CYCLES = PULSE_TIME_US * CLK_MHZ;
    localparam int WD_TIME_MS = 1000;
    localparam int WD_CYCLES = WD_TIME_MS * CLK_MHZ * 1000;

    // ==========================================================
    // Types
    typedef enum logic {CSC_DEFAULT, CSC_HOST} csc_mode_t;

    typedef struct packed {
        logic [2:0] ilim;
        logic full_report;
        logic term;
        logic inhibit;
        logic quiet;
    } csc_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } csc_req_t;

    typedef struct packed {
        logic [NUM_FAULTS-1:0] fault_cond;
        logic charging;
        logic done;
        logic undervoltage_lockout;
        logic psel;
    } csc_pins_t;

    // Input current limit in mA for a limit code
    function automatic logic [11:0] ilim_ma(input logic [2:0] code);
        case (code)
            3'h0: ilim_ma = 12'd100;
            3'h1: ilim_ma = 12'd150;
            3'h2: ilim_ma = 12'd500;
            3'h3: ilim_ma = 12'd900;
            3'h4: ilim_ma = 12'd1500;
            3'h5: ilim_ma = 12'd1950;
            3'h6: ilim_ma = 12'd2500;
            default: ilim_ma = 12'd2000;
        endcase
    endfunction

    // Code of the highest-ranked present fault, zero when none
    function automatic logic [2:0] prio_code(input logic [NUM_FAULTS-1:0] c);
        prio_code = FLT_NONE;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (c[i]) begin
                prio_code = 3'(i + 1);
            end
        end
    endfunction

endpackage

/* File: design/csc_pulse_gen.sv */
// Retriggerable fixed-length notification pulse generator
module csc_pulse_gen #(
    parameter int LEN = 6400
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    output logic pulse_q
);
    localparam int CW = $clog2(LEN + 1);

    // ==========================================================
    // Parameter check
    generate
        if (LEN < 2) begin : g_bad_len
            $error("pulse length must be at least two cycles");
        end
    endgenerate

    logic [CW-1:0] cnt_q;

    // Restart on every event so a burst still ends one full length after the last
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else if (start) begin
            cnt_q <= CW'(LEN - 1);
            pulse_q <= 1'b1;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end else begin
            pulse_q <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    int len_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            len_q <= 0;
        end else if (start) begin
            len_q <= 0;
        end else if (pulse_q) begin
            len_q <= len_q + 1;
        end
    end

    property p_pulse_len;
        @(posedge clock) disable iff (reset) $fell(pulse_q) |-> len_q == LEN;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");

    property p_pulse_start;
        @(posedge clock) disable iff (reset) start |=> pulse_q [*2];
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");
endmodule

/* File: design/csc_regs.sv */
// Status and control register pair of a single-cell charger, with notify pulses
// What this block does
// - Writing 1 to watchdog kick restarts the watchdog; the bit reads 0.
// - Boost select picks charger (0) or boost (1) mode; resets to 0.
// - Read-only charge state tracks ready, charging, done or fault live.
// - Writing 1 to ship latch turns things off until undervoltage lockout falls.
// - Host writing 0 to ship latch returns to normal operation.
// - Three read-only fault bits encode seven fault kinds, zero for none.
// - Several faults at once show only the highest ranked, code 1 first.
// - Fault code sticks until read by the host and condition gone.
// - Every status change or new higher-ranked fault gives one 128 us interrupt pulse; notify pulses too only for faults or when full report is 1.
// - Once a fault clears, charge state shows the present status again.
// - Writing 1 to register reset restores all defaults; it reads 1.
// - Register reset enters default mode and stops the watchdog.
// - Three-bit input limit code selects 100 to 2500 mA; resets to 000.
// - In default mode the limit select pin sets the input limit.
// - Full report enable 0 makes notify show faults only; resets to 1.
// - Termination enable allows charge-current termination when 1; resets to 1.
// - Charge inhibit 1 disables charging; reset value set per variant.
// - Quiet standby 1 puts the device in high impedance; resets to 0.
// - Watchdog expiry in boost clears boost, pulses, shows low supply fault.
// - Reads of undefined offsets return all ones.
module csc_regs
    import csc_pkg::*;
#(
    parameter int PULSE_LEN = csc_pkg::PULSE_CYCLES,
    parameter int WD_LEN = csc_pkg::WD_CYCLES,
    parameter logic INHIBIT_RST = csc_pkg::INHIBIT_RST_DEF
) (
    input wire logic clock,
    input wire logic reset,
    input csc_pkg::csc_req_t req,
    input csc_pkg::csc_pins_t pins_async,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    output logic boost_mode_q,
    output logic ship_off_q,
    output logic ext_switch_on_q,
    output csc_pkg::csc_ctrl_t ctrl_q,
    output logic [2:0] ilim_code_q,
    output logic [11:0] ilim_ma_q,
    output logic default_mode_q,
    output logic notify_q,
    output logic int_q
);
    import csc_pkg::*;

    // ==========================================================
    // Parameter check
    generate
        if (WD_LEN < 2 || PULSE_LEN < 2) begin : g_bad_param
            $error("watchdog and pulse lengths must be at least two cycles");
        end
    endgenerate

    // ==========================================================
    // Pin synchronisers
    csc_pins_t sync1_q;
    csc_pins_t sync2_q;
    logic undervoltage_lockout_prev_q;

    // Analog flags arrive unsynchronised, so two stages before any use
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            undervoltage_lockout_prev_q <= 1'b0;
        end else begin
            sync1_q <= pins_async;
            sync2_q <= sync1_q;
            undervoltage_lockout_prev_q <= sync2_q.undervoltage_lockout;
        end
    end

    wire undervoltage_lockout_fall = undervoltage_lockout_prev_q && !sync2_q.undervoltage_lockout;

    // ==========================================================
    // Access decode
    wire wr_status = req.wr && (req.addr == ADDR_STATUS);
    wire wr_ctrl = req.wr && (req.addr == ADDR_CTRL);
    wire rd_status = req.rd && (req.addr == ADDR_STATUS);
    wire rd_ctrl = req.rd && (req.addr == ADDR_CTRL);
    wire reg_reset = wr_ctrl && req.wdata[CTRL_RESET_BIT];
    wire kick = wr_status && req.wdata[STS_KICK_BIT];

    // ==========================================================
    // Watchdog and mode
    csc_mode_t mode_q;
    csc_mode_t mode_d;
    logic [31:0] wd_cnt_q;
    logic wd_fault_q;
    logic wd_boost_q;

    wire wd_expire = (mode_q == CSC_HOST) && (wd_cnt_q == 32'(WD_LEN - 1));

    // Default mode until the host's first kick; expiry or register reset falls back
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            CSC_DEFAULT: begin
                if (kick) begin
                    mode_d = CSC_HOST;
                end
            end
            CSC_HOST: begin
                if (reg_reset || wd_expire) begin
                    mode_d = CSC_DEFAULT;
                end
            end
            default: mode_d = CSC_DEFAULT;
        endcase
    end

    // Counter only runs in host mode, so default mode means watchdog stopped
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_q <= CSC_DEFAULT;
            wd_cnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            if (kick || mode_d != CSC_HOST) begin
                wd_cnt_q <= '0;
            end else begin
                wd_cnt_q <= wd_cnt_q + 32'h1;
            end
        end
    end

    // Timer fault conditions; expiry in the same cycle as a kick still counts
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wd_fault_q <= 1'b0;
            wd_boost_q <= 1'b0;
        end else if (wd_expire) begin
            wd_fault_q <= 1'b1;
            wd_boost_q <= boost_mode_q;
        end else if (kick || reg_reset) begin
            wd_fault_q <= 1'b0;
            wd_boost_q <= 1'b0;
        end
    end

    // ==========================================================
    // Writable status bits; read-only fields of the write are dropped
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            boost_mode_q <= BOOST_RST;
            ship_off_q <= SHIP_RST;
        end else if (reg_reset) begin
            boost_mode_q <= BOOST_RST;
            ship_off_q <= SHIP_RST;
        end else begin
            if (wd_expire) begin
                boost_mode_q <= 1'b0;
            end else if (wr_status) begin
                boost_mode_q <= req.wdata[STS_BOOST_BIT];
            end
            if (wr_status) begin
                ship_off_q <= req.wdata[STS_SHIP_BIT];
            end else if (undervoltage_lockout_fall) begin
                ship_off_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control register
    localparam csc_ctrl_t CTRL_DEF = '{ilim: ILIM_RST, full_report: FULL_RST,
        term: TERM_RST, inhibit: INHIBIT_RST, quiet: QUIET_RST};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_DEF;
        end else if (reg_reset) begin
            ctrl_q <= CTRL_DEF;
        end else if (wr_ctrl) begin
            ctrl_q.ilim <= req.wdata[CTRL_ILIM_HI:CTRL_ILIM_LO];
            ctrl_q.full_report <= req.wdata[CTRL_FULL_BIT];
            ctrl_q.term <= req.wdata[CTRL_TERM_BIT];
            ctrl_q.inhibit <= req.wdata[CTRL_INHIBIT_BIT];
            ctrl_q.quiet <= req.wdata[CTRL_QUIET_BIT];
        end
    end

    // ==========================================================
    // Fault priority and sticky fault code
    logic [2:0] fault_q;
    logic [1:0] stat_q;
    logic read_seen_q;
    logic [NUM_FAULTS-1:0] fault_cond;

    // Watchdog expiry in boost raises low supply, which outranks the timer fault
    always_comb begin
        fault_cond = sync2_q.fault_cond;
        fault_cond[FLT_IDX_TIMER] = sync2_q.fault_cond[FLT_IDX_TIMER] | wd_fault_q;
        fault_cond[FLT_IDX_LOW_SUPPLY] = sync2_q.fault_cond[FLT_IDX_LOW_SUPPLY]
            | wd_boost_q;
    end

    wire [2:0] present = prio_code(fault_cond);
    wire fault_load = (present != FLT_NONE) && (fault_q == FLT_NONE || present < fault_q);
    wire fault_clear = read_seen_q && (present == FLT_NONE) && (fault_q != FLT_NONE);
    wire [2:0] fault_d = fault_load ? present : (fault_clear ? FLT_NONE : fault_q);
    wire [1:0] stat_d = (fault_d != FLT_NONE) ? ST_FAULT :
                        sync2_q.done ? ST_DONE :
                        sync2_q.charging ? ST_CHARGING : ST_READY;
    wire stat_change = stat_d != stat_q;

    // A new fault wins over a clear in the same cycle and needs a fresh read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fault_q <= FLT_NONE;
            stat_q <= ST_READY;
            read_seen_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
            stat_q <= stat_d;
            if (fault_load || fault_clear) begin
                read_seen_q <= 1'b0;
            end else if (rd_status && fault_q != FLT_NONE) begin
                read_seen_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Notify and interrupt pulses
    wire int_start = fault_load || stat_change;
    wire notify_start = fault_load || (stat_change && ctrl_q.full_report);

    csc_pulse_gen #(.LEN(PULSE_LEN)) u_int_pulse (
        .clock(clock),
        .reset(reset),
        .start(int_start),
        .pulse_q(int_q)
    );

    csc_pulse_gen #(.LEN(PULSE_LEN)) u_notify_pulse (
        .clock(clock),
        .reset(reset),
        .start(notify_start),
        .pulse_q(notify_q)
    );

    // ==========================================================
    // Effective input limit and register read port
    wire [2:0] ilim_code_d = (mode_q == CSC_DEFAULT) ?
        (sync2_q.psel ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW) : ctrl_q.ilim;
    wire [7:0] status_word = {1'b0, boost_mode_q, stat_q, ship_off_q, fault_q};
    wire [7:0] ctrl_word = {1'b1, ctrl_q};
    wire [7:0] rd_word = rd_status ? status_word : (rd_ctrl ? ctrl_word : RD_UNMAPPED);

    // Outputs registered so the pins never glitch on decode changes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            ilim_code_q <= ILIM_PSEL_LOW;
            ilim_ma_q <= 12'h000;
            default_mode_q <= 1'b1;
            ext_switch_on_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) begin
                rdata_q <= rd_word;
            end
            ilim_code_q <= ilim_code_d;
            ilim_ma_q <= ilim_ma(ilim_code_d);
            default_mode_q <= (mode_d == CSC_DEFAULT);
            ext_switch_on_q <= !ship_off_q;
        end
    end

    // ==========================================================
    // Checks
    property p_kick;
        @(posedge clock) disable iff (reset) kick |=> wd_cnt_q == 32'h0 && mode_q == CSC_HOST;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not restart watchdog");

    property p_status_read;
        @(posedge clock) disable iff (reset)
            rd_status |=> rvalid_q && !rdata_q[STS_KICK_BIT] && rdata_q[2:0] == $past(fault_q);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_boost_write;
        @(posedge clock) disable iff (reset)
            wr_status && !wd_expire |=> boost_mode_q == $past(req.wdata[STS_BOOST_BIT]);
    endproperty
    a_boost_write: assert property (p_boost_write) else $error("boost select not written");

    property p_stat_fault;
        @(posedge clock) disable iff (reset) (fault_q != FLT_NONE) == (stat_q == ST_FAULT);
    endproperty
    a_stat_fault: assert property (p_stat_fault) else $error("state disagrees with fault");

    property p_ship_undervoltage_lockout;
        @(posedge clock) disable iff (reset)
            undervoltage_lockout_fall && !wr_status |=> !ship_off_q ##1 ext_switch_on_q;
    endproperty
    a_ship_undervoltage_lockout: assert property (p_ship_undervoltage_lockout) else $error("ship latch not released");

    property p_prio;
        @(posedge clock) disable iff (reset)
            fault_load |=> fault_q == $past(present) && stat_q == ST_FAULT;
    endproperty
    a_prio: assert property (p_prio) else $error("fault priority wrong");

    property p_sticky;
        @(posedge clock) disable iff (reset)
            fault_q != FLT_NONE && !read_seen_q && !fault_load |=> fault_q == $past(fault_q);
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault cleared before read");

    property p_reg_reset;
        @(posedge clock) disable iff (reset)
            reg_reset |=> ctrl_q == CTRL_DEF && default_mode_q && !boost_mode_q
            ##1 wd_cnt_q == 32'h0;
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("register reset wrong");

    property p_default_limit;
        @(posedge clock) disable iff (reset)
            mode_q == CSC_DEFAULT |=>
            ilim_code_q == ($past(sync2_q.psel) ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW);
    endproperty
    a_default_limit: assert property (p_default_limit) else $error("default limit wrong");

    sequence s_boost_dropped;
        !boost_mode_q;
    endsequence
    sequence s_low_supply_shown;
        fault_q <= FLT_LOW_SUPPLY && fault_q != FLT_NONE && int_q;
    endsequence
    property p_wd_boost;
        @(posedge clock) disable iff (reset)
            wd_expire && boost_mode_q && fault_q == FLT_NONE && !reg_reset |=>
            s_boost_dropped ##1 s_low_supply_shown;
    endproperty
    a_wd_boost: assert property (p_wd_boost) else $error("boost expiry mishandled");

    property p_unmapped;
        @(posedge clock) disable iff (reset)
            req.rd && req.addr != ADDR_STATUS && req.addr != ADDR_CTRL |=> rdata_q == RD_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not all ones");
endmodule

/* File: verif/csc_host_model.sv */
// Host-side model that issues single-byte register reads and writes
module csc_host_model (
    input wire logic clock,
    output csc_pkg::csc_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    import csc_pkg::*;

    // Idle fields start non-zero so a decoder cannot lean on quiet buses
    initial req = '{addr: 8'h5a, wr: 1'b0, rd: 1'b0, wdata: 8'ha5};

    // One strobe cycle; idle fields then flip so stale values are never trusted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clock);
        #1;
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule

/* File: verif/csc_regs_tb_top.sv */
// Self-checking bench for the charger status and control registers
module csc_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import csc_pkg::*;

    localparam int PL = 16;
    localparam int WL = 64;
    logic clock, reset;
    csc_req_t req;
    csc_pins_t pins;
    csc_ctrl_t ctrl_q;
    logic [7:0] rdata_q;
    logic rvalid_q, boost_mode_q, ship_off_q, ext_switch_on_q, default_mode_q, notify_q, int_q;
    logic [2:0] ilim_code_q;
    logic [11:0] ilim_ma_q;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [11:0] ma_tab [8] = '{12'd100, 12'd150, 12'd500, 12'd900, 12'd1500, 12'd1950,
                                12'd2500, 12'd2000};

    csc_regs #(.PULSE_LEN(PL), .WD_LEN(WL), .INHIBIT_RST(1'b0)) uut (.clock(clock),
        .reset(reset), .req(req), .pins_async(pins), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .boost_mode_q(boost_mode_q), .ship_off_q(ship_off_q), .ext_switch_on_q(ext_switch_on_q),
        .ctrl_q(ctrl_q), .ilim_code_q(ilim_code_q), .ilim_ma_q(ilim_ma_q),
        .default_mode_q(default_mode_q), .notify_q(notify_q), .int_q(int_q));
    csc_host_model host (.clock(clock), .req(req));

    // ==========================================================
    // Clock, watchdog on the run, shared tasks
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // A hung handshake would otherwise stall the run for ever
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d);
    endtask

    task automatic pulses(output int ni, output int nn);
        ni = 0;
        nn = 0;
        repeat (30) begin
            @(posedge clock);
            #1;
            if (int_q === 1'b1) ni++;
            if (notify_q === 1'b1) nn++;
        end
    endtask

    task automatic wrap_up();
        chk("pending reads", 12'd0, 12'(exp_q.size()));
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Read data watcher: each answer retires the oldest expectation
    always @(posedge clock) begin
        if (rvalid_q === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 12'd0, 12'd1);
            else chk("rdata", {4'h0, exp_q.pop_front()}, {4'h0, rdata_q});
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] d;
        int ni, nn;
        reset = 1'b1;
        pins = '0;
        void'($urandom(32'he0d2));
        repeat (12) @(posedge clock);
        #1;
        reset = 1'b0;
        rd(ADDR_STATUS, 8'h00);
        rd(ADDR_CTRL, 8'h8c);
        rd(8'h05, RD_UNMAPPED);
        chk("ilim_ma psel0", 12'd1500, ilim_ma_q);
        chk("ilim_code psel0", {9'h0, ILIM_PSEL_LOW}, {9'h0, ilim_code_q});
        pins.psel = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chk("ilim_ma psel1", 12'd500, ilim_ma_q);
        $display("test defaults done");
        // Random control bytes; bit 7 kept low so no register reset fires
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom) & 8'h7f;
            wr(ADDR_CTRL, d);
            chk("ctrl_q", {5'h0, d[6:0]}, {5'h0, ctrl_q});
            rd(ADDR_CTRL, d | 8'h80);
        end
        wr(8'h07, 8'h00);
        rd(ADDR_CTRL, d | 8'h80);
        $display("test control done");
        // Kick, boost, ship and the read-only bits in one write
        wr(ADDR_STATUS, 8'hff);
        chk("default_mode", 12'd0, {11'h0, default_mode_q});
        chk("ship_off", 12'd1, {11'h0, ship_off_q});
        rd(ADDR_STATUS, 8'h48);
        chk("ilim_ma host", ma_tab[d[6:4]], ilim_ma_q);
        chk("ilim_code host", {9'h0, d[6:4]}, {9'h0, ilim_code_q});
        pins.undervoltage_lockout = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        pins.undervoltage_lockout = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        chk("ship after undervoltage_lockout", 12'd0, {11'h0, ship_off_q});
        chk("ext switch", 12'd1, {11'h0, ext_switch_on_q});
        wr(ADDR_STATUS, 8'h48);
        wr(ADDR_STATUS, 8'h40);
        chk("ship by host", 12'd0, {11'h0, ship_off_q});
        repeat (WL + 8) @(posedge clock);
        #1;
        chk("boost expiry", 12'd0, {11'h0, boost_mode_q});
        chk("default expiry", 12'd1, {11'h0, default_mode_q});
        rd(ADDR_STATUS, 8'h32);
        wr(ADDR_CTRL, 8'h80);
        chk("ctrl after reset", 12'h00c, {5'h0, ctrl_q});
        repeat (6) @(posedge clock);
        rd(ADDR_STATUS, 8'h00);
        $display("test status done");
        // Every fault code, each with the lowest ranked one beside it
        pins.charging = 1'b1;
        for (int i = 0; i < 7; i++) begin
            pins.fault_cond = 7'(7'h01 << i) | 7'h40;
            repeat (6) @(posedge clock);
            #1;
            pins.fault_cond = '0;
            repeat (6) @(posedge clock);
            rd(ADDR_STATUS, 8'h30 | 8'(i + 1));
            repeat (4) @(posedge clock);
            rd(ADDR_STATUS, 8'h10);
        end
        $display("test faults done");
        // Status-only change with full report off, then a fault
        repeat (20) @(posedge clock);
        wr(ADDR_CTRL, 8'h04);
        pins.done = 1'b1;
        pulses(ni, nn);
        chk("int width", 12'(PL), 12'(ni));
        chk("notify muted", 12'd0, 12'(nn));
        rd(ADDR_STATUS, 8'h20);
        pins.fault_cond = 7'h04;
        pulses(ni, nn);
        chk("notify fault", 12'(PL), 12'(nn));
        $display("test pulses done");
        repeat (4) @(posedge clock);
        wrap_up();
    end
endmodule
